// [cocs_pkg.sv]
package cocs_pkg;
   // register offsets
   localparam logic [7:0] REG_PHASE    = 8'h04;
   localparam logic [7:0] REG_SYNC_SEL = 8'h1d;
   localparam logic [7:0] REG_CLK_SEL  = 8'h20;
   localparam logic [7:0] REG_HS_CTRL  = 8'h12;
   localparam logic [7:0] REG_HS_WIDTH = 8'h13;
   localparam logic [7:0] REG_STATUS   = 8'h2f;
   // reset values
   localparam logic [7:0] RST_PHASE    = 8'h80;
   localparam logic [7:0] RST_SYNC_SEL = 8'h00;
   localparam logic [7:0] RST_CLK_SEL  = 8'h00;
   localparam logic [7:0] RST_HS_CTRL  = 8'h80;
   localparam logic [7:0] RST_HS_WIDTH = 8'h20;
   // field positions
   localparam int SYNC_SEL_LSB = 0;
   localparam int CLK_SEL_LSB  = 6;
   localparam int PHASE_LSB    = 3;
   localparam int HS_POL_BIT   = 7;
   localparam int EXT_SRC_BIT  = 6;
   localparam int ST_FIELD_BIT = 0;
   localparam int ST_HS_BIT    = 1;
   localparam int ST_EXT_BIT   = 2;
   // timing
   localparam int PHASE_STEPS  = 32;
   localparam int PIX_DIV_DEF  = 32;
   localparam int LINE_W       = 12;
   localparam int I2C_ACK_BIT  = 8;
   localparam int I2C_END_BIT  = 9;
   // arbitrary value, not tied to any part
   localparam logic [6:0] DEV_ADDR_DEF = 7'h4c;

   typedef enum logic [1:0] {
      SRC_RAW_SOG   = 2'h0,
      SRC_RAW_HS    = 2'h1,
      SRC_REGEN_HS  = 2'h2,
      SRC_FILT_HS   = 2'h3
   } cocs_sync_src_e;

   typedef enum logic [1:0] {
      CK_PIXEL  = 2'h0,
      CK_QUAD   = 2'h1,
      CK_DOUBLE = 2'h2,
      CK_HALF   = 2'h3
   } cocs_clk_form_e;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_DEV  = 5'h02,
      ST_PTR  = 5'h04,
      ST_WDAT = 5'h08,
      ST_RDAT = 5'h10
   } cocs_i2c_st_e;
endpackage : cocs_pkg

// [cocs_cfg_if.sv]
interface cocs_cfg_if;
   logic       wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;

   modport target (
      output wr_en,
      output wr_addr,
      output wr_data,
      output rd_addr,
      input  rd_data
   );
   modport regs (
      input  wr_en,
      input  wr_addr,
      input  wr_data,
      input  rd_addr,
      output rd_data
   );
endinterface : cocs_cfg_if

// [cocs_i2c_target.sv]
module cocs_i2c_target
   import cocs_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
   input  wire logic   clk,
   input  wire logic   reset,
   input  wire logic   scl_in,
   input  wire logic   sda_in,
   output logic        sda_oe,
   cocs_cfg_if.target  cfg
);
   cocs_i2c_st_e st_ff, nxt_st;
   logic [3:0] bit_ff, nxt_bit;
   logic [7:0] sh_ff, nxt_sh;
   logic [7:0] ptr_ff, nxt_ptr;
   logic       oe_ff, nxt_oe;
   logic       rw_ff, nxt_rw;
   logic       nack_ff, nxt_nack;
   logic       wr_ff, nxt_wr;
   logic [7:0] wa_ff, nxt_wa;
   logic       scl_q_ff, sda_q_ff;
   logic       start, stop, rise, fall;

   assign start = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
   assign stop  = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
   assign rise  = scl_in & ~scl_q_ff;
   assign fall  = ~scl_in & scl_q_ff;

   assign sda_oe      = oe_ff;
   assign cfg.wr_en   = wr_ff;
   assign cfg.wr_addr = wa_ff;
   assign cfg.wr_data = sh_ff;
   assign cfg.rd_addr = ptr_ff;

   always_comb begin
      nxt_st   = st_ff;
      nxt_bit  = bit_ff;
      nxt_sh   = sh_ff;
      nxt_ptr  = ptr_ff;
      nxt_oe   = oe_ff;
      nxt_rw   = rw_ff;
      nxt_nack = nack_ff;
      nxt_wr   = 1'b0;
      nxt_wa   = wa_ff;
      if (start) begin
         nxt_st  = ST_DEV;
         nxt_bit = 4'h0;
         nxt_oe  = 1'b0;
      end else if (stop) begin
         nxt_st = ST_IDLE;
         nxt_oe = 1'b0;
      end else if (st_ff != ST_IDLE && rise) begin
         if (bit_ff < 4'(I2C_ACK_BIT)) begin
            if (st_ff != ST_RDAT)
               nxt_sh = {sh_ff[6:0], sda_in};
            nxt_bit = bit_ff + 4'h1;
         end else if (bit_ff == 4'(I2C_END_BIT))
            nxt_nack = sda_in;
      end else if (st_ff != ST_IDLE && fall) begin
         if (bit_ff == 4'(I2C_ACK_BIT)) begin
            nxt_bit = 4'(I2C_END_BIT);
            nxt_oe  = 1'b1;
            case (st_ff)
               ST_DEV: begin
                  nxt_rw = sh_ff[0];
                  if (sh_ff[7:1] != DEV_ADDR) begin
                     nxt_st = ST_IDLE;
                     nxt_oe = 1'b0;
                  end
               end
               ST_PTR: nxt_ptr = sh_ff;
               ST_WDAT: begin
                  nxt_wr  = 1'b1;
                  nxt_wa  = ptr_ff;
                  nxt_ptr = ptr_ff + 8'h01;
               end
               default: nxt_oe = 1'b0;
            endcase
         end else if (bit_ff == 4'(I2C_END_BIT)) begin
            nxt_bit = 4'h0;
            nxt_oe  = 1'b0;
            case (st_ff)
               ST_DEV:  nxt_st = rw_ff ? ST_RDAT : ST_PTR;
               ST_PTR:  nxt_st = ST_WDAT;
               ST_RDAT: if (nack_ff) nxt_st = ST_IDLE;
               default: nxt_st = st_ff;
            endcase
            if ((st_ff == ST_DEV && rw_ff) ||
                (st_ff == ST_RDAT && !nack_ff)) begin
               nxt_sh  = cfg.rd_data;
               nxt_oe  = ~cfg.rd_data[7];
               nxt_ptr = ptr_ff + 8'h01;
            end
         end else if (st_ff == ST_RDAT)
            nxt_oe = ~sh_ff[3'(4'h7 - bit_ff)];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff    <= ST_IDLE;
         bit_ff   <= 4'h0;
         sh_ff    <= 8'h00;
         ptr_ff   <= 8'h00;
         oe_ff    <= 1'b0;
         rw_ff    <= 1'b0;
         nack_ff  <= 1'b0;
         wr_ff    <= 1'b0;
         wa_ff    <= 8'h00;
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         st_ff    <= nxt_st;
         bit_ff   <= nxt_bit;
         sh_ff    <= nxt_sh;
         ptr_ff   <= nxt_ptr;
         oe_ff    <= nxt_oe;
         rw_ff    <= nxt_rw;
         nack_ff  <= nxt_nack;
         wr_ff    <= nxt_wr;
         wa_ff    <= nxt_wa;
         scl_q_ff <= scl_in;
         sda_q_ff <= sda_in;
      end
   end
endmodule : cocs_i2c_target

// [cocs_top.sv]
module cocs_top
   import cocs_pkg::*;
#(
   parameter int         PIX_DIV  = PIX_DIV_DEF,
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic [7:0] red_in,
   input  wire logic [7:0] green_in,
   input  wire logic [7:0] blue_in,
   input  wire logic       hsync_in,
   input  wire logic       green_embedded_sync,
   input  wire logic       vsync_in,
   input  wire logic       external_pixel_clock_in,
   output logic [7:0]      red_out,
   output logic [7:0]      green_out,
   output logic [7:0]      blue_out,
   output logic            pixel_data_strobe_out,
   output logic            line_sync_out,
   output logic            sliced_sync_out,
   output logic            field_odd_out
);
   localparam int CW = $clog2(PIX_DIV);

   if (PIX_DIV < PHASE_STEPS || (PIX_DIV & (PIX_DIV - 1)) != 0) begin : g_chk
      $error("PIX_DIV must be a power of two of at least 32");
   end

   cocs_cfg_if cfg ();

   // open drain: only ever pulls low
   assign sda_out = 1'b0;

   cocs_i2c_target #(
      .DEV_ADDR (DEV_ADDR)
   ) u_i2c (
      .clk    (clk),
      .reset  (reset),
      .scl_in (scl_in),
      .sda_in (sda_in),
      .sda_oe (sda_oe),
      .cfg    (cfg)
   );

   // ---------------- registers ----------------
   logic [7:0] phase_ff, nxt_phase;
   logic [7:0] sync_sel_ff, nxt_sync_sel;
   logic [7:0] clk_sel_ff, nxt_clk_sel;
   logic [7:0] hs_ctrl_ff, nxt_hs_ctrl;
   logic [7:0] hs_width_ff, nxt_hs_width;
   logic       field_ff, nxt_field;
   logic       filt_ff, nxt_filt;

   always_comb begin
      nxt_phase    = phase_ff;
      nxt_sync_sel = sync_sel_ff;
      nxt_clk_sel  = clk_sel_ff;
      nxt_hs_ctrl  = hs_ctrl_ff;
      nxt_hs_width = hs_width_ff;
      if (cfg.wr_en) begin
         case (cfg.wr_addr)
            REG_PHASE:    nxt_phase    = cfg.wr_data;
            REG_SYNC_SEL: nxt_sync_sel = cfg.wr_data;
            REG_CLK_SEL:  nxt_clk_sel  = cfg.wr_data;
            REG_HS_CTRL:  nxt_hs_ctrl  = cfg.wr_data;
            REG_HS_WIDTH: nxt_hs_width = cfg.wr_data;
            default:      nxt_phase    = phase_ff;
         endcase
      end
   end

   always_comb begin
      case (cfg.rd_addr)
         REG_PHASE:    cfg.rd_data = phase_ff;
         REG_SYNC_SEL: cfg.rd_data = sync_sel_ff;
         REG_CLK_SEL:  cfg.rd_data = clk_sel_ff;
         REG_HS_CTRL:  cfg.rd_data = hs_ctrl_ff;
         REG_HS_WIDTH: cfg.rd_data = hs_width_ff;
         REG_STATUS: begin
            cfg.rd_data = 8'h00;
            cfg.rd_data[ST_FIELD_BIT] = field_ff;
            cfg.rd_data[ST_HS_BIT]    = filt_ff;
            cfg.rd_data[ST_EXT_BIT]   = external_pixel_clock_in;
         end
         default:      cfg.rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         phase_ff    <= RST_PHASE;
         sync_sel_ff <= RST_SYNC_SEL;
         clk_sel_ff  <= RST_CLK_SEL;
         hs_ctrl_ff  <= RST_HS_CTRL;
         hs_width_ff <= RST_HS_WIDTH;
      end else begin
         phase_ff    <= nxt_phase;
         sync_sel_ff <= nxt_sync_sel;
         clk_sel_ff  <= nxt_clk_sel;
         hs_ctrl_ff  <= nxt_hs_ctrl;
         hs_width_ff <= nxt_hs_width;
      end
   end

   // ---------------- pixel timing ----------------
   logic [CW-1:0]  base_ff, nxt_base;
   logic           ext_q_ff;
   logic           half_ff, nxt_half;
   cocs_clk_form_e form_ff, nxt_form;
   logic           strobe_ff, nxt_strobe;
   logic [CW-1:0]  pos;
   logic           sample, mid, swap;
   logic           f_pix, f_quad, f_dbl, f_half;

   // every data clock form and the data are timed off pos, so a phase
   // step shifts them all by the same amount
   assign pos    = base_ff - CW'(phase_ff[7:PHASE_LSB]);
   assign sample = pos == '0;
   assign mid    = pos == CW'(PIX_DIV / 2);
   // all forms are low here, so a select change cannot cut a pulse
   assign swap   = (pos == CW'(PIX_DIV - 1)) && half_ff;
   assign f_pix  = pos < CW'(PIX_DIV / 2);
   assign f_quad = pos >= CW'(PIX_DIV / 4) && pos < CW'(3 * PIX_DIV / 4);
   assign f_dbl  = ~pos[CW-2];
   assign f_half = sample ? half_ff : ~half_ff;

   always_comb begin
      nxt_base = base_ff + CW'(1);
      // external clock edge realigns the pixel grid to the outside source
      if (hs_ctrl_ff[EXT_SRC_BIT] && external_pixel_clock_in && !ext_q_ff)
         nxt_base = '0;
      nxt_half = sample ? ~half_ff : half_ff;
      nxt_form = swap ? cocs_clk_form_e'(clk_sel_ff[CLK_SEL_LSB +: 2])
                      : form_ff;
      case (form_ff)
         CK_PIXEL:  nxt_strobe = f_pix;
         CK_QUAD:   nxt_strobe = f_quad;
         CK_DOUBLE: nxt_strobe = f_dbl;
         CK_HALF:   nxt_strobe = f_half;
         default:   nxt_strobe = f_pix;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         base_ff   <= '0;
         ext_q_ff  <= 1'b0;
         half_ff   <= 1'b0;
         form_ff   <= CK_PIXEL;
         strobe_ff <= 1'b0;
      end else begin
         base_ff   <= nxt_base;
         ext_q_ff  <= external_pixel_clock_in;
         half_ff   <= nxt_half;
         form_ff   <= nxt_form;
         strobe_ff <= nxt_strobe;
      end
   end

   // ---------------- pixel data and syncs ----------------
   logic [23:0]       cap_ff, nxt_cap, dout_ff, nxt_dout;
   logic [2:0]        hs_hist_ff, nxt_hs_hist;
   logic              sog_ff, nxt_sog;
   logic [7:0]        regen_ff, nxt_regen;
   logic [LINE_W-1:0] lc_ff, nxt_lc, len_ff, nxt_len;
   logic              vs_q_ff, nxt_vs_q;
   logic              lso_ff, nxt_lso, sso_ff, nxt_sso;
   logic              maj, regen_act, line_sync;

   assign maj = (hs_hist_ff[0] & hs_hist_ff[1]) |
                (hs_hist_ff[1] & hs_hist_ff[2]) |
                (hs_hist_ff[0] & hs_hist_ff[2]);
   assign regen_act = regen_ff != 8'h00;
   assign line_sync = regen_act ^ ~hs_ctrl_ff[HS_POL_BIT];

   always_comb begin
      nxt_cap     = cap_ff;
      nxt_dout    = dout_ff;
      nxt_hs_hist = hs_hist_ff;
      nxt_sog     = sog_ff;
      nxt_filt    = filt_ff;
      nxt_regen   = regen_ff;
      nxt_lc      = lc_ff;
      nxt_len     = len_ff;
      nxt_vs_q    = vs_q_ff;
      nxt_field   = field_ff;
      nxt_lso     = lso_ff;
      nxt_sso     = sso_ff;
      if (sample) begin
         nxt_cap     = {red_in, green_in, blue_in};
         nxt_hs_hist = {hs_hist_ff[1:0], hsync_in};
         nxt_sog     = green_embedded_sync;
         nxt_filt    = maj;
         nxt_vs_q    = vsync_in;
         nxt_lc      = lc_ff + LINE_W'(1);
         if (regen_act)
            nxt_regen = regen_ff - 8'h01;
         if (maj && !filt_ff) begin
            nxt_regen = hs_width_ff;
            nxt_len   = lc_ff;
            nxt_lc    = '0;
         end
         // vsync late in the line marks the second field
         if (vsync_in && !vs_q_ff)
            nxt_field = lc_ff >= (len_ff >> 1);
      end
      // data and syncs change one fixed half period after capture,
      // which is where the strobe falls in the pixel form only
      if (mid) begin
         nxt_dout = cap_ff;
         nxt_lso  = line_sync;
         case (cocs_sync_src_e'(sync_sel_ff[SYNC_SEL_LSB +: 2]))
            SRC_RAW_SOG:  nxt_sso = sog_ff;
            SRC_RAW_HS:   nxt_sso = hs_hist_ff[0];
            SRC_REGEN_HS: nxt_sso = regen_act;
            SRC_FILT_HS:  nxt_sso = filt_ff;
            default:      nxt_sso = sog_ff;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cap_ff     <= 24'h000000;
         dout_ff    <= 24'h000000;
         hs_hist_ff <= 3'h0;
         sog_ff     <= 1'b0;
         filt_ff    <= 1'b0;
         regen_ff   <= 8'h00;
         lc_ff      <= '0;
         len_ff     <= '0;
         vs_q_ff    <= 1'b0;
         field_ff   <= 1'b0;
         lso_ff     <= 1'b0;
         sso_ff     <= 1'b0;
      end else begin
         cap_ff     <= nxt_cap;
         dout_ff    <= nxt_dout;
         hs_hist_ff <= nxt_hs_hist;
         sog_ff     <= nxt_sog;
         filt_ff    <= nxt_filt;
         regen_ff   <= nxt_regen;
         lc_ff      <= nxt_lc;
         len_ff     <= nxt_len;
         vs_q_ff    <= nxt_vs_q;
         field_ff   <= nxt_field;
         lso_ff     <= nxt_lso;
         sso_ff     <= nxt_sso;
      end
   end

   // in the pixel form, outside logic latches on the strobe rising edge,
   // mid-way in the stable data window
   assign red_out               = dout_ff[23:16];
   assign green_out             = dout_ff[15:8];
   assign blue_out              = dout_ff[7:0];
   assign pixel_data_strobe_out = strobe_ff;
   assign line_sync_out         = lso_ff;
   assign sliced_sync_out       = sso_ff;
   assign field_odd_out         = field_ff;
endmodule : cocs_top

// [cocs_monitor.sv]
module cocs_monitor
   import cocs_pkg::*;
#(
   parameter int PIX_DIV = PIX_DIV_DEF
) (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       scl_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic [7:0] red_in,
   input wire logic       vsync_in,
   input wire logic [7:0] red_out,
   input wire logic       pixel_data_strobe_out,
   input wire logic       line_sync_out,
   input wire logic       field_odd_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   logic [15:0] run_ff, vs_age_ff, din_age_ff;

   // reset counts as a red_in change, not a vsync rise: the grid restarts after it
   always_ff @(posedge clk) begin
      if (reset) begin
         run_ff     <= 16'h0000;
         vs_age_ff  <= 16'hffff;
         din_age_ff <= 16'h0000;
      end else begin
         if ($changed(pixel_data_strobe_out)) run_ff <= 16'h0000;
         else run_ff <= run_ff + 16'h0001;
         if ($rose(vsync_in)) vs_age_ff <= 16'h0000;
         else if (vs_age_ff != 16'hffff) vs_age_ff <= vs_age_ff + 16'h0001;
         if ($changed(red_in)) din_age_ff <= 16'h0000;
         else if (din_age_ff != 16'hffff) din_age_ff <= din_age_ff + 16'h0001;
      end
   end

   sda_low_a:
      assert property (sda_out == 1'b0) else $error("sda driven high");
   ack_edge_a:
      assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
         else $error("sda moved while scl high");
   ack_hold_a:
      assert property ($rose(sda_oe) |=> sda_oe [*3])
         else $error("sda pull too short");
   reset_zero_a:
      assert property ($fell(reset) |-> red_out == 8'h00 && !sda_oe &&
                       !pixel_data_strobe_out && !line_sync_out)
         else $error("outputs not cleared by reset");
   strobe_high_a:
      assert property ($rose(pixel_data_strobe_out) |->
                       pixel_data_strobe_out [*8])
         else $error("runt high on data clock");
   strobe_low_a:
      assert property ($fell(pixel_data_strobe_out) |->
                       !pixel_data_strobe_out [*8])
         else $error("runt low on data clock");
   strobe_run_a:
      assert property (run_ff < 2 * PIX_DIV) else $error("data clock stalled");
   data_src_a:
      assert property ($changed(red_out) |-> din_age_ff <= 3 * PIX_DIV)
         else $error("data changed without input change");
   field_src_a:
      assert property ($changed(field_odd_out) |-> vs_age_ff <= 3 * PIX_DIV)
         else $error("field moved without vsync");

   cover property ($rose(sda_oe));
   cover property ($changed(field_odd_out));
   cover property ($fell(line_sync_out));
endmodule : cocs_monitor

bind cocs_top cocs_monitor #(.PIX_DIV(PIX_DIV)) u_mon (
   .clk(clk), .reset(reset), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .red_in(red_in), .vsync_in(vsync_in),
   .red_out(red_out), .pixel_data_strobe_out(pixel_data_strobe_out),
   .line_sync_out(line_sync_out), .field_odd_out(field_odd_out)
);

// [cocs_sink.sv]
module cocs_sink (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        strobe,
   input wire logic [23:0] rgb,
   input wire logic        line_sync,
   output logic [23:0]     word,
   output int              period,
   output int              high_len,
   output int              lat_d,
   output int              lat_h,
   output int              t_rise
);
   timeunit 1ns;
   timeprecision 1ns;
   int          cyc;
   logic        st_q, ls_q;
   logic [23:0] rgb_q;

   // latencies are taken from the last data clock rise
   always @(posedge clk) begin
      if (reset) begin
         cyc    <= 0;
         st_q   <= 1'b0;
         t_rise <= 0;
      end else begin
         cyc   <= cyc + 1;
         st_q  <= strobe;
         rgb_q <= rgb;
         ls_q  <= line_sync;
         if (strobe && !st_q) begin
            word   <= rgb;
            period <= cyc - t_rise;
            t_rise <= cyc;
         end
         if (!strobe && st_q) high_len <= cyc - t_rise;
         if (rgb !== rgb_q) lat_d <= cyc - t_rise;
         if (line_sync !== ls_q) lat_h <= cyc - t_rise;
      end
   end
endmodule : cocs_sink

// [tb.sv]
module tb
   import cocs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int         P  = PIX_DIV_DEF;
   localparam logic [6:0] DA = DEV_ADDR_DEF;
   logic        clk = 1'b0, reset = 1'b1, scl = 1'b1, sda_m = 1'b1;
   logic        hs = 1'b0, gs = 1'b0, vs = 1'b0, ek = 1'b0;
   logic [7:0]  r_in = 8'h00, g_in = 8'h00, b_in = 8'h00;
   logic [7:0]  r_o, g_o, b_o, rd;
   logic        sda_o, sda_oe, strobe, ls, ss, fo;
   logic [23:0] word;
   int          period, high_len, lat_d, lat_h, t_rise, t0, n;
   int          n_mismatch = 0;
   int          checks = 0;
   int          per[4] = '{P, P, P / 2, 2 * P};
   int          hig[4] = '{P / 2, P / 2, P / 4, P};
   int          lat[2] = '{P / 2, P / 4};
   logic [23:0] pat[3] = '{24'hff00a5, 24'h00ff5a, 24'h123456};
   wire logic   sda = sda_m & ~sda_oe;

   always #25 clk = ~clk;

   cocs_top DUT (
      .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_o), .sda_oe(sda_oe), .red_in(r_in), .green_in(g_in),
      .blue_in(b_in), .hsync_in(hs), .green_embedded_sync(gs),
      .vsync_in(vs), .external_pixel_clock_in(ek), .red_out(r_o),
      .green_out(g_o), .blue_out(b_o), .pixel_data_strobe_out(strobe),
      .line_sync_out(ls), .sliced_sync_out(ss), .field_odd_out(fo)
   );
   cocs_sink u_sink (
      .clk(clk), .reset(reset), .strobe(strobe), .rgb({r_o, g_o, b_o}),
      .line_sync(ls), .word(word), .period(period), .high_len(high_len),
      .lat_d(lat_d), .lat_h(lat_h), .t_rise(t_rise)
   );

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wt(input int k);
      repeat (k) @(negedge clk);
   endtask : wt

   // sda only moves mid-way through scl low
   task automatic bit_x(input logic b, output logic r);
      wt(2);
      sda_m = b;
      wt(2);
      scl = 1'b1;
      wt(4);
      r = sda;
      scl = 1'b0;
   endtask : bit_x

   task automatic byte_x(input logic [7:0] d, input logic ma,
                         output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(ma, ack);
   endtask : byte_x

   task automatic start_c;
      sda_m = 1'b1;
      wt(2);
      scl = 1'b1;
      wt(4);
      sda_m = 1'b0;
      wt(4);
      scl = 1'b0;
   endtask : start_c

   task automatic stop_c;
      wt(2);
      sda_m = 1'b0;
      wt(2);
      scl = 1'b1;
      wt(4);
      sda_m = 1'b1;
      wt(4);
   endtask : stop_c

   task automatic wr(input logic [6:0] dev, input logic [7:0] a, d,
                     input logic nak);
      logic [7:0] q;
      logic       k0, k1, k2;
      start_c;
      byte_x({dev, 1'b0}, 1'b1, q, k0);
      byte_x(a, 1'b1, q, k1);
      byte_x(d, 1'b1, q, k2);
      stop_c;
      chk("write ack", {k0, k1, k2}, {3{nak}});
   endtask : wr

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] q;
      logic       k0, k1, k2, k3;
      start_c;
      byte_x({DA, 1'b0}, 1'b1, q, k0);
      byte_x(a, 1'b1, q, k1);
      start_c;
      byte_x({DA, 1'b1}, 1'b1, q, k2);
      byte_x(8'hff, 1'b1, d, k3);
      stop_c;
      chk("read ack", {k0, k1, k2}, 3'b000);
   endtask : rd_reg

   task automatic hs_pulse(output int len);
      logic lvl;
      int   k;
      lvl = ls;
      hs = 1'b1;
      for (k = 0; k < 4 * P && ls === lvl; k++) wt(1);
      for (len = 0; len < 8 * P && ls !== lvl; len++) wt(1);
      hs = 1'b0;
      wt(4 * P);
   endtask : hs_pulse

   task automatic line_x(input int vpos);
      for (int px = 0; px < 16; px++) begin
         hs = (px < 2);
         vs = (px >= vpos);
         wt(P);
      end
   endtask : line_x

   initial begin
      wt(5);
      reset = 1'b0;
      rd_reg(REG_PHASE, rd);
      chk("phase reset", rd, RST_PHASE);
      rd_reg(REG_SYNC_SEL, rd);
      chk("sync select reset", rd, RST_SYNC_SEL);
      rd_reg(REG_CLK_SEL, rd);
      chk("clock select reset", rd, RST_CLK_SEL);
      wr(DA, REG_SYNC_SEL, 8'h02, 1'b0);
      wr(DA ^ 7'h01, REG_SYNC_SEL, 8'h01, 1'b1);
      rd_reg(REG_SYNC_SEL, rd);
      chk("sync select rw", rd, 8'h02);
      rd_reg(8'h30, rd);
      chk("unmapped read", rd, 8'h00);
      $display("registers test done");
      for (int i = 0; i < 3; i++) begin
         {r_in, g_in, b_in} = pat[i];
         wt(4 * P);
         chk("latched word", word, pat[i]);
         chk("output word", {r_o, g_o, b_o}, pat[i]);
      end
      $display("data test done");
      for (int f = 0; f < 4; f++) begin
         wr(DA, REG_CLK_SEL, 8'(f << CLK_SEL_LSB), 1'b0);
         wt(3 * P);
         r_in = 8'(f);
         wt(5 * P);
         chk("strobe period", period, per[f]);
         chk("strobe high", high_len, hig[f]);
         if (f < 2) chk("strobe to data", lat_d, lat[f]);
      end
      $display("clock form test done");
      wr(DA, REG_CLK_SEL, RST_CLK_SEL, 1'b0);
      wr(DA, REG_HS_WIDTH, 8'h03, 1'b0);
      wt(4 * P);
      t0 = t_rise % P;
      wr(DA, REG_PHASE, 8'h88, 1'b0);
      r_in = 8'h77;
      hs_pulse(n);
      chk("line pulse", n, 3 * P);
      chk("phase shift", (t_rise % P - t0 + P) % P, 1);
      chk("data after shift", lat_d, P / 2);
      chk("line sync after shift", lat_h, P / 2);
      wr(DA, REG_HS_CTRL, 8'h00, 1'b0);
      wt(4 * P);
      chk("inverted idle", ls, 1'b1);
      hs_pulse(n);
      chk("inverted pulse", n, 3 * P);
      wr(DA, REG_HS_CTRL, RST_HS_CTRL, 1'b0);
      $display("phase and line sync test done");
      for (int s = 0; s < 2; s++) begin
         gs = !s;
         hs = s[0];
         wt(8 * P);
         for (int m = 0; m < 4; m++) begin
            wr(DA, REG_SYNC_SEL, 8'(m), 1'b0);
            wt(4 * P);
            chk("sliced sync", ss, m == 0 ? gs : m == 2 ? 1'b0 : hs);
         end
      end
      $display("sync select test done");
      line_x(99);
      line_x(99);
      line_x(12);
      chk("odd field", fo, 1'b1);
      line_x(99);
      line_x(4);
      chk("even field", fo, 1'b0);
      rd_reg(REG_STATUS, rd);
      chk("status field", rd[ST_FIELD_BIT], 1'b0);
      $display("field test done");
      wr(DA, REG_HS_CTRL, 8'hc0, 1'b0);
      while (strobe !== 1'b0) wt(1);
      while (strobe !== 1'b1) wt(1);
      // phase step 17 puts the sample at grid count 17, so this edge
      // meets count 0 and only holds the grid back by one clk
      wt(P - 18);
      ek = 1'b1;
      wt(P);
      chk("external realign", period, P + 1);
      rd_reg(REG_STATUS, rd);
      chk("status ext clock", rd[ST_EXT_BIT], 1'b1);
      $display("external clock test done");
      finish_test;
   end

   initial begin
      repeat (50000) @(posedge clk);
      n_mismatch++;
      finish_test;
   end
endmodule : tb
